// ===== core/ccc_pkg.sv
package ccc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [9:0] TIMER_DIVIDER_CH1 = 10'h111;
  localparam logic [9:0] DAC_MAILBOX_SELECT_CH1 = 10'h112;
  localparam logic [9:0] HALT_KEY_CH1 = 10'h113;
  localparam logic [9:0] TIMER_DIVIDER_CH2 = 10'h131;
  localparam logic [9:0] DAC_MAILBOX_SELECT_CH2 = 10'h132;
  localparam logic [9:0] HALT_KEY_CH2 = 10'h133;
  localparam logic [9:0] TIMER_DIVIDER_CH3 = 10'h151;
  localparam logic [9:0] DAC_MAILBOX_SELECT_CH3 = 10'h152;
  localparam logic [9:0] HALT_KEY_CH3 = 10'h153;
  localparam logic [9:0] CH_STRIDE = 10'h020;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] HALT_KEY = 16'hbeef;
  // ****************************************
  // field positions in the select word
  // ****************************************
  localparam int SPLIT0_BIT = 0;
  localparam int SPLIT1_BIT = 1;
  localparam int DIR0_BIT = 2;
  localparam int DIR1_BIT = 3;
  localparam int PICK0_BIT = 4;
  localparam int PICK1_BIT = 5;
  localparam int MBOX0_LSB = 8;
  localparam int MBOX1_LSB = 11;
  localparam logic [15:0] SELECT_MASK = 16'h3f3f;
  // ****************************************
  // mailbox target codes
  // ****************************************
  localparam logic [2:0] MB_OWN_SAME = 3'h0;
  localparam logic [2:0] MB_PEER_SAME = 3'h1;
  localparam logic [2:0] MB_OWN_NEXT = 3'h2;
  localparam logic [2:0] MB_PEER_NEXT = 3'h3;
  localparam logic [2:0] MB_SUM_HIGH = 3'h4;
  localparam logic [2:0] MB_SUM_SECOND = 3'h5;
  localparam logic [2:0] MB_OWN_PREV = 3'h6;
  localparam logic [2:0] MB_PEER_PREV = 3'h7;

  // per-core routing bundle
  typedef struct packed {
    logic [2:0] dac_own_a;
    logic [2:0] dac_own_b;
    logic [2:0] dac_nbr_a;
    logic [2:0] dac_nbr_b;
    logic [2:0] special_dac_slot;
    logic       control_word_split;
    logic [2:0] mbox_target;
  } ccc_route_t;

  // microcode instruction strobe per core
  typedef struct packed {
    logic       dac_instr;
    logic       neighbour_dac_direction;
    logic       special_dac_pick;
    logic       mbox_instr;
    logic [2:0] mbox_target;
  } ccc_instr_t;
endpackage

// ===== core/ccc_channel_config.sv
// Contract
// - divider codes 0 to 11 divide the core clock by code plus one.
// - divider codes 12 to 15 divide by 14, 16, 32 and 64.
// - the divider word holds four codes, first core timers in 7:0, second core timers in 15:8.
// - each core reaches its own channel's two dacs and exactly two dacs of one neighbour.
// - first core own pair is dac 2n-1,2n; direction 0 picks next channel, 1 the previous.
// - second core uses the same channel choice but presents each pair even before odd.
// - the special dac pick routes the special slot to dac 5 when 0 and dac 6 when 1.
// - direction and special pick follow the latest of register write or core instruction.
// - split 0 leaves all 16 control bits as control; split 1 makes the top 8 shared status.
// - mailbox codes 0,1,2,3,6,7 select own/peer core in own, next or previous channel.
// - mailbox codes 4 and 5 present the sums of the top and second nibbles of all mailboxes.
// - next channel wraps 3 to 1, previous wraps 1 to 3, peer is the other core of the pair.
// - the mailbox target is set by register or instruction and selects one core, or the sums over all six mailboxes for codes 4 and 5.
// - writing the exact key to the halt address stops the channel's cores.
// - the halt address holds no storage and reads there return no meaningful data.
module ccc_channel_config #(
  parameter int CH = 1
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // register port
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  input  wire logic [9:0]              addr,
  input  wire logic [15:0]             wdata,
  output logic      [15:0]             rdata,
  // core instructions
  input  wire ccc_pkg::ccc_instr_t     instr_c0,
  input  wire ccc_pkg::ccc_instr_t     instr_c1,
  // all six mailbox words, index = 2*(channel-1)+core
  input  wire logic [5:0][15:0]        mailbox_all,
  // control words from both cores
  input  wire logic [15:0]             ctrl_word_c0,
  input  wire logic [15:0]             ctrl_word_c1,
  // routing out
  output ccc_pkg::ccc_route_t          route_c0,
  output ccc_pkg::ccc_route_t          route_c1,
  output logic      [15:0]             mailbox_view_c0,
  output logic      [15:0]             mailbox_view_c1,
  output logic      [7:0]              shared_status_c0,
  output logic      [7:0]              shared_status_c1,
  // timer tick enables: c0 t3, c0 t4, c1 t3, c1 t4
  output logic      [3:0]              timer_tick,
  output logic                         halt_ff
);
  if (CH < 1 || CH > 3) begin : g_bad_ch
    $error("channel must be 1 to 3");
  end

  // ****************************************
  // address decode
  // ****************************************
  localparam logic [9:0] OFS = 10'(ccc_pkg::CH_STRIDE * (CH - 1));
  logic [9:0] a_div;
  logic [9:0] a_sel;
  logic [9:0] a_key;
  assign a_div = ccc_pkg::TIMER_DIVIDER_CH1 + OFS;
  assign a_sel = ccc_pkg::DAC_MAILBOX_SELECT_CH1 + OFS;
  assign a_key = ccc_pkg::HALT_KEY_CH1 + OFS;

  wire hit_div = wr_en && addr == a_div;
  wire hit_sel = wr_en && addr == a_sel;
  wire key_ok  = wr_en && addr == a_key && wdata == ccc_pkg::HALT_KEY;

  logic [15:0] div_ff;
  logic [15:0] sel_ff;
  logic [15:0] nxt_div;
  logic [15:0] nxt_sel;
  logic [15:0] instr_sel;

  assign nxt_div = hit_div ? wdata : div_ff;

  // instruction updates overlay the stored fields; a same-cycle
  // register write wins because it is applied last
  always_comb begin
    instr_sel = sel_ff;
    if (instr_c0.dac_instr) begin
      instr_sel[ccc_pkg::DIR0_BIT]  = instr_c0.neighbour_dac_direction;
      instr_sel[ccc_pkg::PICK0_BIT] = instr_c0.special_dac_pick;
    end
    if (instr_c1.dac_instr) begin
      instr_sel[ccc_pkg::DIR1_BIT]  = instr_c1.neighbour_dac_direction;
      instr_sel[ccc_pkg::PICK1_BIT] = instr_c1.special_dac_pick;
    end
    if (instr_c0.mbox_instr)
      instr_sel[ccc_pkg::MBOX0_LSB +: 3] = instr_c0.mbox_target;
    if (instr_c1.mbox_instr)
      instr_sel[ccc_pkg::MBOX1_LSB +: 3] = instr_c1.mbox_target;
  end
  assign nxt_sel = hit_sel ? (wdata & ccc_pkg::SELECT_MASK) : instr_sel;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff  <= ccc_pkg::REG_RESET;
      sel_ff  <= ccc_pkg::REG_RESET;
      halt_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      sel_ff  <= nxt_sel;
      halt_ff <= halt_ff | key_ok;
    end
  end

  // ****************************************
  // read back; key address has no storage
  // ****************************************
  logic [15:0] nxt_rdata;
  assign nxt_rdata = (addr == a_div) ? div_ff :
                     (addr == a_sel) ? sel_ff : 16'h0000;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= 16'h0000;
    else if (rd_en) rdata <= nxt_rdata;
  end

  // ****************************************
  // timer dividers
  // ****************************************
  function automatic logic [6:0] ratio(input logic [3:0] code);
    case (code)
      4'hc:    ratio = 7'd14;
      4'hd:    ratio = 7'd16;
      4'he:    ratio = 7'd32;
      4'hf:    ratio = 7'd64;
      default: ratio = {3'h0, code} + 7'd1;
    endcase
  endfunction

  logic [3:0] tick_ff;
  assign timer_tick = tick_ff;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_div
      logic [6:0] cnt_ff;
      logic [6:0] lim;
      assign lim = ratio(div_ff[4*g +: 4]) - 7'd1;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_ff     <= 7'h00;
          tick_ff[g] <= 1'b0;
        end else begin
          tick_ff[g] <= cnt_ff >= lim;
          cnt_ff     <= (cnt_ff >= lim) ? 7'h00 : cnt_ff + 7'd1;
        end
      end
    end
  endgenerate

  // ****************************************
  // dac and mailbox routing
  // ****************************************
  localparam logic [1:0] C = 2'(CH);
  localparam logic [1:0] NXT = (C == 2'd3) ? 2'd1 : C + 2'd1;
  localparam logic [1:0] PRV = (C == 2'd1) ? 2'd3 : C - 2'd1;

  function automatic logic [2:0] odd_dac(input logic [1:0] ch);
    odd_dac = {ch, 1'b0} - 3'd1;
  endfunction

  wire dir0 = sel_ff[ccc_pkg::DIR0_BIT];
  wire dir1 = sel_ff[ccc_pkg::DIR1_BIT];
  wire [1:0] nb0 = dir0 ? PRV : NXT;
  wire [1:0] nb1 = dir1 ? PRV : NXT;

  function automatic logic [15:0] mb(input logic [5:0][15:0] all, input logic [1:0] ch,
                                     input logic core);
    mb = all[{2'h0, ch} * 3'd2 - 3'd2 + {2'h0, core}];
  endfunction

  // six nibbles reach 90, so the sums need seven bits
  logic [6:0] sum_hi;
  logic [6:0] sum_2nd;
  always_comb begin
    sum_hi  = 7'h00;
    sum_2nd = 7'h00;
    for (int i = 0; i < 6; i++) begin
      sum_hi  = sum_hi + {3'h0, mailbox_all[i][15:12]};
      sum_2nd = sum_2nd + {3'h0, mailbox_all[i][11:8]};
    end
  end

  function automatic logic [15:0] mbsel(input logic [2:0] code, input logic core,
                                        input logic [5:0][15:0] all,
                                        input logic [6:0] sh, input logic [6:0] s2);
    case (code)
      ccc_pkg::MB_OWN_SAME:   mbsel = mb(all, C, core);
      ccc_pkg::MB_PEER_SAME:  mbsel = mb(all, C, ~core);
      ccc_pkg::MB_OWN_NEXT:   mbsel = mb(all, NXT, core);
      ccc_pkg::MB_PEER_NEXT:  mbsel = mb(all, NXT, ~core);
      ccc_pkg::MB_SUM_HIGH:   mbsel = {9'h000, sh};
      ccc_pkg::MB_SUM_SECOND: mbsel = {9'h000, s2};
      ccc_pkg::MB_OWN_PREV:   mbsel = mb(all, PRV, core);
      default:                mbsel = mb(all, PRV, ~core);
    endcase
  endfunction

  ccc_pkg::ccc_route_t nxt_r0;
  ccc_pkg::ccc_route_t nxt_r1;
  always_comb begin
    nxt_r0.dac_own_a = odd_dac(C);
    nxt_r0.dac_own_b = odd_dac(C) + 3'd1;
    nxt_r0.dac_nbr_a = odd_dac(nb0);
    nxt_r0.dac_nbr_b = odd_dac(nb0) + 3'd1;
    nxt_r0.special_dac_slot = sel_ff[ccc_pkg::PICK0_BIT] ? 3'd6 : 3'd5;
    nxt_r0.control_word_split = sel_ff[ccc_pkg::SPLIT0_BIT];
    nxt_r0.mbox_target = sel_ff[ccc_pkg::MBOX0_LSB +: 3];
    nxt_r1.dac_own_a = odd_dac(C) + 3'd1;
    nxt_r1.dac_own_b = odd_dac(C);
    nxt_r1.dac_nbr_a = odd_dac(nb1) + 3'd1;
    nxt_r1.dac_nbr_b = odd_dac(nb1);
    nxt_r1.special_dac_slot = sel_ff[ccc_pkg::PICK1_BIT] ? 3'd6 : 3'd5;
    nxt_r1.control_word_split = sel_ff[ccc_pkg::SPLIT1_BIT];
    nxt_r1.mbox_target = sel_ff[ccc_pkg::MBOX1_LSB +: 3];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      route_c0 <= '0;
      route_c1 <= '0;
      mailbox_view_c0 <= 16'h0000;
      mailbox_view_c1 <= 16'h0000;
      shared_status_c0 <= 8'h00;
      shared_status_c1 <= 8'h00;
    end else begin
      route_c0 <= nxt_r0;
      route_c1 <= nxt_r1;
      mailbox_view_c0 <= mbsel(sel_ff[ccc_pkg::MBOX0_LSB +: 3], 1'b0, mailbox_all,
                               sum_hi, sum_2nd);
      mailbox_view_c1 <= mbsel(sel_ff[ccc_pkg::MBOX1_LSB +: 3], 1'b1, mailbox_all,
                               sum_hi, sum_2nd);
      // upper byte is status only when split; zero otherwise
      shared_status_c0 <= sel_ff[ccc_pkg::SPLIT0_BIT] ? ctrl_word_c0[15:8] : 8'h00;
      shared_status_c1 <= sel_ff[ccc_pkg::SPLIT1_BIT] ? ctrl_word_c1[15:8] : 8'h00;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_halt_key;
    @(posedge clk) disable iff (!rst_n) key_ok |=> halt_ff;
  endproperty
  a_halt_key: assert property (p_halt_key) else $error("halt not set");

  property p_bad_key;
    @(posedge clk) disable iff (!rst_n)
      (wr_en && addr == a_key && wdata != ccc_pkg::HALT_KEY && !halt_ff) |=> !halt_ff;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key halted");

  property p_div_wr;
    @(posedge clk) disable iff (!rst_n) hit_div |=> div_ff == $past(wdata);
  endproperty
  a_div_wr: assert property (p_div_wr) else $error("divider not stored");

  property p_tick_64;
    @(posedge clk) disable iff (!rst_n)
      (div_ff[3:0] == 4'hf && !hit_div) [*8] |-> !(tick_ff[0] && $past(tick_ff[0]));
  endproperty
  a_tick_64: assert property (p_tick_64) else $error("tick too fast");

  property p_tick_1;
    @(posedge clk) disable iff (!rst_n)
      (div_ff[3:0] == 4'h0) [*3] |-> tick_ff[0];
  endproperty
  a_tick_1: assert property (p_tick_1) else $error("ratio 1 not every cycle");

  property p_special;
    @(posedge clk) disable iff (!rst_n)
      1 |=> route_c0.special_dac_slot == ($past(sel_ff[ccc_pkg::PICK0_BIT]) ? 3'd6 : 3'd5);
  endproperty
  a_special: assert property (p_special) else $error("special dac wrong");

  property p_pair_order;
    @(posedge clk) disable iff (!rst_n)
      1 |=> route_c1.dac_nbr_a == route_c1.dac_nbr_b + 3'd1 &&
            route_c0.dac_own_b == route_c0.dac_own_a + 3'd1;
  endproperty
  a_pair_order: assert property (p_pair_order) else $error("pair order");

  property p_instr;
    @(posedge clk) disable iff (!rst_n)
      (instr_c0.dac_instr && !hit_sel) |=>
        sel_ff[ccc_pkg::DIR0_BIT] == $past(instr_c0.neighbour_dac_direction);
  endproperty
  a_instr: assert property (p_instr) else $error("instruction ignored");

  property p_split;
    @(posedge clk) disable iff (!rst_n)
      !sel_ff[ccc_pkg::SPLIT0_BIT] ##1 !sel_ff[ccc_pkg::SPLIT0_BIT] |-> shared_status_c0 == 8'h00;
  endproperty
  a_split: assert property (p_split) else $error("status leak");

  c_halt: cover property (@(posedge clk) disable iff (!rst_n) key_ok);
  c_sum: cover property (@(posedge clk) disable iff (!rst_n)
    sel_ff[ccc_pkg::MBOX0_LSB +: 3] == ccc_pkg::MB_SUM_HIGH);
  c_prev: cover property (@(posedge clk) disable iff (!rst_n) dir1 && route_c1.dac_nbr_a != 3'd0);
endmodule

// ===== tb/ccc_host_model.sv
module ccc_host_model (
  // clock
  input  wire logic        clk,
  // register port
  output logic             wr_en,
  output logic             rd_en,
  output logic [9:0]       addr,
  output logic [15:0]      wdata,
  input  wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 10'h000;
    wdata = 16'h0000;
  end
  // released data goes inverted so a stale word never looks valid
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    wdata = ~d;
  endtask
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    d = 16'h0000;
    if (a[4:0] != 5'h13) begin
      @(negedge clk);
      addr  = a;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      d     = rdata;
    end
  endtask
endmodule

// ===== tb/ccc_channel_core_config_regs_test.sv
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module ccc_channel_core_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] DIV = ccc_pkg::TIMER_DIVIDER_CH2;
  localparam logic [9:0] SEL = ccc_pkg::DAC_MAILBOX_SELECT_CH2;
  localparam logic [9:0] KEY = ccc_pkg::HALT_KEY_CH2;
  logic                clk, rst_n, wr_en, rd_en, halt_ff;
  logic [9:0]          addr;
  logic [15:0]         wdata, rdata, ctrl0, ctrl1, vw0, vw1, d;
  logic [5:0][15:0]    mb;
  logic [7:0]          st0, st1;
  logic [3:0]          tick;
  ccc_pkg::ccc_instr_t in0, in1;
  ccc_pkg::ccc_route_t rt0, rt1;
  int                  err_count, num_checks;

  // ****************************************
  // clock, design and host
  // ****************************************
  always #20 clk = ~clk;
  ccc_channel_config #(.CH(2)) ccc_channel_config_i (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .instr_c0(in0), .instr_c1(in1),
    .mailbox_all(mb), .ctrl_word_c0(ctrl0), .ctrl_word_c1(ctrl1),
    .route_c0(rt0), .route_c1(rt1), .mailbox_view_c0(vw0), .mailbox_view_c1(vw1),
    .shared_status_c0(st0), .shared_status_c1(st1), .timer_tick(tick), .halt_ff(halt_ff));
  ccc_host_model ccc_host_model_i (
    .clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));

  // ****************************************
  // expectations
  // ****************************************
  function automatic int ratio(input logic [3:0] c);
    case (c)
      4'hc: return 14;
      4'hd: return 16;
      4'he: return 32;
      4'hf: return 64;
      default: return c + 1;
    endcase
  endfunction
  // channel 2: next is 3, previous is 1
  function automatic ccc_pkg::ccc_route_t exp_route(input logic c, input logic [15:0] s);
    ccc_pkg::ccc_route_t r;
    logic [2:0] n;
    n = s[2+c] ? 3'h1 : 3'h3;
    r.dac_own_a = c ? 3'h4 : 3'h3;
    r.dac_own_b = c ? 3'h3 : 3'h4;
    r.dac_nbr_a = 3'(n * 2 - 1 + c);
    r.dac_nbr_b = 3'(n * 2 - c);
    r.special_dac_slot = s[4+c] ? 3'h6 : 3'h5;
    r.control_word_split = s[c];
    r.mbox_target = c ? s[13:11] : s[10:8];
    return r;
  endfunction
  function automatic logic [15:0] exp_view(input logic c, input logic [2:0] k);
    logic [6:0] sh, s2;
    sh = 7'h00;
    s2 = 7'h00;
    for (int i = 0; i < 6; i++) begin
      sh += 7'(mb[i][15:12]);
      s2 += 7'(mb[i][11:8]);
    end
    case (k)
      3'h4: return {9'h000, sh};
      3'h5: return {9'h000, s2};
      default: return mb[(k[2] ? 0 : k[1] ? 4 : 2) + (k[0] ^ c)];
    endcase
  endfunction

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check_sel(input logic [15:0] s);
    repeat (4) @(negedge clk);
    `CHK("route_c0", exp_route(1'b0, s), rt0)
    `CHK("route_c1", exp_route(1'b1, s), rt1)
    `CHK("view_c0", exp_view(1'b0, s[10:8]), vw0)
    `CHK("view_c1", exp_view(1'b1, s[13:11]), vw1)
    `CHK("status_c0", s[0] ? ctrl0[15:8] : 8'h00, st0)
    `CHK("status_c1", s[1] ? ctrl1[15:8] : 8'h00, st1)
  endtask
  // counting over whole periods avoids phase dependence
  task automatic tick_run(input logic [15:0] w, input int win);
    int n[4];
    ccc_host_model_i.wr(DIV, w);
    ccc_host_model_i.rd(DIV, d);
    `CHK("divider", w, d)
    n = '{0, 0, 0, 0};
    repeat (130) @(negedge clk);
    repeat (win) begin
      @(negedge clk);
      for (int k = 0; k < 4; k++) n[k] += int'(tick[k]);
    end
    for (int k = 0; k < 4; k++) `CHK("ticks", win / ratio(w[4*k+:4]), n[k])
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    #1000000;
    err_count++;
    conclude();
  end
  initial begin
    logic [15:0] s;
    clk = 1'b0;
    rst_n = 1'b0;
    in0 = '0;
    in1 = '0;
    mb = '0;
    ctrl0 = 16'h0000;
    ctrl1 = 16'h0000;
    void'($urandom(23));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    ccc_host_model_i.rd(SEL, d);
    `CHK("sel_reset", ccc_pkg::REG_RESET, d)
    check_sel(16'h0000);
    $display("test reset done");
    for (int c = 0; c < 16; c++) tick_run({4{4'(c)}}, 4 * ratio(4'(c)));
    tick_run(16'h7310, 64);
    $display("test divider done");
    for (int i = 0; i < 8; i++) begin
      s = 16'($urandom);
      s[10:8] = 3'(i);
      s[13:11] = 3'(7 - i);
      for (int k = 0; k < 6; k++) mb[k] = 16'($urandom);
      ctrl0 = 16'($urandom);
      ctrl1 = 16'($urandom);
      ccc_host_model_i.wr(SEL, s);
      ccc_host_model_i.rd(SEL, d);
      `CHK("sel_read", s & ccc_pkg::SELECT_MASK, d)
      check_sel(s);
    end
    $display("test select done");
    ccc_host_model_i.wr(SEL, 16'h0000);
    @(negedge clk);
    in0.dac_instr = 1'b1;
    in0.neighbour_dac_direction = 1'b1;
    in0.special_dac_pick = 1'b1;
    in0.mbox_instr = 1'b1;
    in0.mbox_target = 3'h6;
    in1.dac_instr = 1'b1;
    in1.neighbour_dac_direction = 1'b1;
    in1.mbox_instr = 1'b1;
    in1.mbox_target = 3'h5;
    @(negedge clk);
    in0 = '0;
    in1 = '0;
    check_sel(16'h2e1c);
    ccc_host_model_i.rd(SEL, d);
    `CHK("sel_instr", 16'h2e1c, d)
    // same edge: the register write must win over the instruction
    fork
      ccc_host_model_i.wr(SEL, 16'h0000);
      begin
        @(negedge clk);
        in0.dac_instr = 1'b1;
        in0.neighbour_dac_direction = 1'b1;
        @(negedge clk);
        in0 = '0;
      end
    join
    check_sel(16'h0000);
    $display("test instruction done");
    ccc_host_model_i.wr(10'h130, 16'hffff);
    ccc_host_model_i.rd(10'h130, d);
    `CHK("unmapped", 16'h0000, d)
    ccc_host_model_i.rd(DIV, d);
    `CHK("div_kept", 16'h7310, d)
    ccc_host_model_i.wr(KEY, 16'hbeee);
    repeat (3) @(negedge clk);
    `CHK("halt_wrong", 1'b0, halt_ff)
    ccc_host_model_i.wr(KEY, ccc_pkg::HALT_KEY);
    for (int t = 0; t < 4 && halt_ff !== 1'b1; t++) @(negedge clk);
    `CHK("halt_key", 1'b1, halt_ff)
    if (halt_ff !== 1'b1) conclude();
    ccc_host_model_i.wr(KEY, 16'h0000);
    @(negedge clk);
    `CHK("halt_sticky", 1'b1, halt_ff)
    // mid-run reset: halt and registers return to zero
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK("halt_reset", 1'b0, halt_ff)
    ccc_host_model_i.rd(DIV, d);
    `CHK("div_reset", ccc_pkg::REG_RESET, d)
    $display("test halt done");
    conclude();
  end
endmodule
